// ===== card_bridge_irq_props.sv
/* Port-level assertions for the card bridge interrupt block.
   Assumes a bind onto the top module and the shared register map. */
`include "card_irq_map.vh"
`default_nettype none
module card_bridge_irq_props (
  input wire logic mclk, // PCI clock
  input wire logic sys_rst, // Sync reset
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  input wire logic [7:0] reg_addr, // Offset
  input wire logic [3:0] reg_be, // Byte enables
  input wire logic [31:0] reg_rdata, // Read data
  input wire logic [1:0] card_idle, // Idle sockets
  input wire logic [1:0] card_clock_stopped, // Gated card clocks
  input wire logic power_change_start, // Power pulse
  input wire logic [6:0] multifunction_terminals, // Terminal drive
  input wire logic [6:0] multifunction_terminals_oe, // Terminal enable
  input wire logic [6:0] multifunction_terminals_in, // Terminal pins
  input wire logic serial_interrupt_line_oe // Serial enable
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****
  // Assertions
  // ****
  default clocking @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  a_pwr_start_write: assert property (reg_wr && ((reg_addr == `OFS_CARD_POWER_CONTROL &&
    reg_be[0]) || (reg_addr == `OFS_SOCKET_CONTROL && reg_be != 4'h0)) |=> power_change_start)
    else $error("power change pulse missing after write");
  a_pwr_needs_write: assert property (power_change_start |-> $past(reg_wr))
    else $error("power change pulse without a write");
  a_pwr_one_cycle: assert property (power_change_start && !reg_wr |=> !power_change_start)
    else $error("power change pulse too long");
  a_reset_quiet: assert property ($fell(sys_rst) |-> multifunction_terminals_oe == 7'h00 &&
    !serial_interrupt_line_oe && card_clock_stopped == 2'h0 && !power_change_start)
    else $error("outputs not inactive after reset");
  a_card_stop_idle: assert property ((card_clock_stopped & ~$past(card_clock_stopped) &
    ~$past(card_idle)) == 2'h0)
    else $error("card clock stopped on a busy socket");
  a_rdata_stands: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");
  a_unmapped_zero: assert property (reg_rd && reg_addr == 8'h40 |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  a_clkrun_after_high: assert property ($rose(multifunction_terminals_oe[6]) &&
    !multifunction_terminals[6] |-> $past(multifunction_terminals_in[6]))
    else $error("clock run driven while host held it low");
  c_pwr: cover property (power_change_start);
  c_serial: cover property ($rose(serial_interrupt_line_oe));
  c_stop: cover property ($rose(card_clock_stopped[0]));
endmodule // card_bridge_irq_props
bind card_bridge_irq_smi_clkrun card_bridge_irq_props u_card_bridge_irq_props (
  .mclk(mclk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_be(reg_be), .reg_rdata(reg_rdata), .card_idle(card_idle),
  .card_clock_stopped(card_clock_stopped), .power_change_start(power_change_start),
  .multifunction_terminals(multifunction_terminals),
  .multifunction_terminals_oe(multifunction_terminals_oe),
  .multifunction_terminals_in(multifunction_terminals_in),
  .serial_interrupt_line_oe(serial_interrupt_line_oe));
`default_nettype wire

// ===== card_bridge_irq_smi_clkrun.v
/*
 * Interrupt routing, maintenance interrupt and clock-run control for a
 * two-socket card bridge. Registers are reached through the bridge's own
 * register strobe port at their printed offsets; runs on the PCI clock.
 */
`include "card_irq_map.vh"
`default_nettype none

module card_bridge_irq_smi_clkrun (
  input wire mclk, // PCI clock, 200 MHz
  input wire sys_rst, // Synchronous reset, active high
  input wire reg_wr, // Register write strobe
  input wire reg_rd, // Register read strobe
  input wire reg_sock, // Socket select for per-socket registers
  input wire [7:0] reg_addr, // Register byte offset
  input wire [3:0] reg_be, // Byte enables
  input wire [31:0] reg_wdata, // Write data
  output reg [31:0] reg_rdata, // Read data
  input wire [1:0] card_functional_irq, // Functional IRQ per socket, high = asserted
  input wire [1:0] status_event, // Status change event pulse per socket
  input wire [1:0] status_mask, // Status change source enable per socket
  input wire [1:0] card_wake_request, // Wake or ring event per socket
  input wire [1:0] card_bus_request, // Card bus request per socket
  input wire [1:0] card_clock_run_in, // Card clock-run level per socket
  output reg [1:0] card_clock_run_out, // Card clock-run drive value
  output reg [1:0] card_clock_run_oe, // Card clock-run drive enable
  output reg [1:0] card_clock_stopped, // Card clock gated off per socket
  input wire [1:0] card_idle, // Socket has no activity
  input wire resource_busy, // 16-bit resource manager busy
  input wire cb_master_busy, // Card bus master busy
  input wire pci_master_busy, // PCI master with posted data
  output reg power_change_start, // Power change sequence pulse
  output reg [6:0] multifunction_terminals, // Terminal drive value
  output reg [6:0] multifunction_terminals_oe, // Terminal drive enable
  input wire [6:0] multifunction_terminals_in, // Terminal pin level
  input wire serial_interrupt_line_in, // Serial line level
  output wire serial_interrupt_line_out, // Serial line drive value
  output wire serial_interrupt_line_oe // Serial line drive enable
);

  // ****************************************
  // Registers
  // ****************************************
  reg [31:0] system_control_r;
  reg [31:0] terminal_routing_r;
  reg [7:0] device_control_r;
  reg [7:0] card_power_control_r [0:1];
  reg [31:0] socket_control_r [0:1];
  reg [7:0] legacy_global_control_r [0:1];
  reg [1:0] maint_irq_pending_r;
  reg [1:0] maint_pending_d_r;
  reg [1:0] status_flag_r;
  reg [1:0] status_d_r;
  reg [1:0] csc_pulse_r;
  reg [1:0] ccr_state_r [0:1];
  reg clock_run_drive_r;
  wire [1:0] csc_src;

  wire sel = reg_sock;
  wire maint_irq_route_sel = system_control_r[`SC_MAINT_ROUTE];
  wire maint_irq_enable = system_control_r[`SC_MAINT_ENABLE];
  wire hold_host_clock = system_control_r[`SC_HOLD_HOST_CLOCK];
  wire [1:0] irq_mode = device_control_r[`DC_MODE_MSB:`DC_MODE_LSB];

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] be;
    begin
      merge = {be[3] ? nw[31:24] : old[31:24], be[2] ? nw[23:16] : old[23:16],
               be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
    end
  endfunction

  wire wr_sys = reg_wr && (reg_addr == `OFS_SYSTEM_CONTROL);
  wire wr_pwr = reg_wr && (reg_addr == `OFS_CARD_POWER_CONTROL) && reg_be[0];
  wire wr_sock = reg_wr && (reg_addr == `OFS_SOCKET_CONTROL) && (|reg_be);
  wire pwr_write = wr_pwr || wr_sock;
  wire [1:0] maint_set = {2{pwr_write && maint_irq_enable}} &
                         {sel, ~sel};
  wire [1:0] maint_clr = {2{wr_sys && reg_be[3] && reg_wdata[`SC_MAINT_PENDING]}} &
                         {sel, ~sel};

  // ****************************************
  // Register writes
  // ****************************************
  always @(posedge mclk) begin
    if (sys_rst) begin
      system_control_r <= `RST_SYSTEM_CONTROL;
      terminal_routing_r <= `RST_TERMINAL_ROUTING;
      device_control_r <= `RST_DEVICE_CONTROL;
      card_power_control_r[0] <= `RST_BYTE;
      card_power_control_r[1] <= `RST_BYTE;
      socket_control_r[0] <= 32'h0000_0000;
      socket_control_r[1] <= 32'h0000_0000;
      legacy_global_control_r[0] <= `RST_BYTE;
      legacy_global_control_r[1] <= `RST_BYTE;
      power_change_start <= 1'b0;
    end else begin
      power_change_start <= pwr_write;
      // Pending bit is write-one-to-clear, kept out of storage
      if (wr_sys)
        system_control_r <= merge(system_control_r, reg_wdata, reg_be) &
                            ~(32'h0000_0001 << `SC_MAINT_PENDING);
      if (reg_wr && reg_addr == `OFS_TERMINAL_ROUTING)
        terminal_routing_r <= merge(terminal_routing_r, reg_wdata, reg_be);
      if (reg_wr && reg_addr == `OFS_DEVICE_CONTROL && reg_be[0])
        device_control_r <= reg_wdata[7:0];
      if (wr_pwr)
        card_power_control_r[sel] <= reg_wdata[7:0];
      if (wr_sock)
        socket_control_r[sel] <= merge(socket_control_r[sel], reg_wdata, reg_be);
      if (reg_wr && reg_addr == `OFS_LEGACY_GLOBAL_CONTROL && reg_be[0])
        legacy_global_control_r[sel] <= reg_wdata[7:0];
    end
  end

  // ****************************************
  // Maintenance interrupt and status change
  // ****************************************
  always @(posedge mclk) begin
    if (sys_rst) begin
      maint_irq_pending_r <= 2'h0;
      maint_pending_d_r <= 2'h0;
      status_flag_r <= 2'h0;
      status_d_r <= 2'h0;
      csc_pulse_r <= 2'h0;
    end else begin
      maint_irq_pending_r <= (maint_irq_pending_r & ~maint_clr) | maint_set;
      maint_pending_d_r <= maint_irq_pending_r;
      status_flag_r <= (status_flag_r & ~(csc_pulse_r & ~status_event)) |
                       (status_event & status_mask);
      status_d_r <= csc_src;
      // Edge mode gives one pulse per new event
      csc_pulse_r <= csc_src & ~status_d_r;
    end
  end

  // Shared route: status change when clear
  wire [1:0] maint_to_csc = maint_irq_pending_r & {2{~maint_irq_route_sel}};
  assign csc_src = status_flag_r | maint_to_csc;
  wire [1:0] edge_mode = {legacy_global_control_r[1][`LGC_LEVEL_EDGE],
                          legacy_global_control_r[0][`LGC_LEVEL_EDGE]};
  wire [1:0] csc_out = (edge_mode & csc_pulse_r) | (~edge_mode & csc_src);
  wire maint_irq2 = maint_irq_route_sel && (|maint_irq_pending_r);
  wire func_any = |card_functional_irq;
  wire inta_level = (|csc_out) || func_any;

  // ****************************************
  // Legacy IRQ vector and parallel terminals
  // ****************************************
  reg [15:0] irq_vec;
  integer t;
  always @* begin
    irq_vec = 16'h0000;
    irq_vec[2] = maint_irq2;
  end

  reg [6:0] term_nxt;
  reg [6:0] term_oe_nxt;
  reg [3:0] code;
  always @* begin
    term_nxt = 7'h7F;
    term_oe_nxt = 7'h00;
    code = 4'h0;
    for (t = 0; t < 7; t = t + 1) begin
      code = terminal_routing_r[t*4 +: 4];
      if (t == 0) begin
        // Terminal zero as INTA, open drain
        if (code == `ROUTE_INTA && irq_mode != `MODE_ALL_SERIAL) begin
          term_nxt[0] = 1'b0;
          // INTA in parallel and IRQ-serial modes
          term_oe_nxt[0] = inta_level;
        end
      end else if (t == 6 && code == `ROUTE_CLOCK_RUN) begin
        // Clock-run open drain on terminal six
        term_nxt[6] = 1'b0;
        term_oe_nxt[6] = clock_run_drive_r;
      end else if (code != `ROUTE_NONE && irq_mode == `MODE_PARALLEL) begin
        term_oe_nxt[t] = 1'b1;
        term_nxt[t] = irq_vec[code];
        // Active-low IRQ2 only on terminal three; code 2 on terminal six is clock run
        if (code == 4'h2)
          term_nxt[t] = (t == 3 || t == 6) ? ~maint_irq2 : 1'b1;
        if (code == 4'h2 && !(t == 3 || t == 6))
          term_oe_nxt[t] = 1'b0;
      end
    end
  end

  always @(posedge mclk) begin
    if (sys_rst) begin
      multifunction_terminals <= 7'h7F;
      multifunction_terminals_oe <= 7'h00;
    end else begin
      multifunction_terminals <= term_nxt;
      multifunction_terminals_oe <= term_oe_nxt;
    end
  end

  // ****************************************
  // Serial interrupt frame
  // ****************************************
  wire ser_en = irq_mode != `MODE_PARALLEL;
  wire [3:0] intx = {3'h0, inta_level && irq_mode == `MODE_ALL_SERIAL};
  serial_irq_frame u_frame (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .enable(ser_en),
    .slot_state({intx, irq_vec}),
    .line_in(serial_interrupt_line_in),
    .line_out(serial_interrupt_line_out),
    .line_oe(serial_interrupt_line_oe),
    .busy()
  );

  // ****************************************
  // Host clock run and card clock managers
  // ****************************************
  wire irq_pending = inta_level || maint_irq2;
  // Busy, pending or running card clock refuses stop
  wire refuse_stop = hold_host_clock || resource_busy || cb_master_busy ||
                     pci_master_busy || irq_pending || (card_clock_stopped != 2'h3);
  wire restart = func_any || (|status_event) || (|card_wake_request) ||
                 (|card_bus_request) || (|(~card_clock_run_in & card_clock_stopped));
  wire host_run_low = ~multifunction_terminals_in[6];

  always @(posedge mclk) begin
    if (sys_rst) begin
      clock_run_drive_r <= 1'b0;
    end else begin
      // Assert clock-run when host deasserts it and stop refused or restart requested
      clock_run_drive_r <= (!host_run_low) && (refuse_stop || restart);
    end
  end

  localparam CC_RUN = 2'h0;
  localparam CC_ASK = 2'h1;
  localparam CC_STOP = 2'h2;
  genvar s;
  generate
    for (s = 0; s < 2; s = s + 1) begin : g_cc
      always @(posedge mclk) begin
        if (sys_rst) begin
          ccr_state_r[s] <= CC_RUN;
          card_clock_run_out[s] <= 1'b1;
          card_clock_run_oe[s] <= 1'b0;
          card_clock_stopped[s] <= 1'b0;
        end else begin
          case (ccr_state_r[s])
            CC_RUN: begin
              card_clock_stopped[s] <= 1'b0;
              card_clock_run_out[s] <= 1'b1;
              card_clock_run_oe[s] <= card_idle[s];
              if (card_idle[s])
                ccr_state_r[s] <= CC_ASK;
            end
            CC_ASK: begin
              card_clock_run_oe[s] <= 1'b0;
              if (!card_idle[s])
                ccr_state_r[s] <= CC_RUN;
              else if (card_clock_run_in[s])
                ccr_state_r[s] <= CC_STOP;
            end
            CC_STOP: begin
              card_clock_stopped[s] <= 1'b1;
              if (!card_idle[s] || !card_clock_run_in[s])
                ccr_state_r[s] <= CC_RUN;
            end
            default: ccr_state_r[s] <= CC_RUN;
          endcase
        end
      end
    end
  endgenerate

  // ****************************************
  // Register reads
  // ****************************************
  always @(posedge mclk) begin
    if (sys_rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `OFS_SYSTEM_CONTROL:
          reg_rdata <= system_control_r |
                       ({31'h0, maint_irq_pending_r[sel]} << `SC_MAINT_PENDING);
        `OFS_TERMINAL_ROUTING: reg_rdata <= terminal_routing_r;
        `OFS_DEVICE_CONTROL: reg_rdata <= {24'h0, device_control_r};
        `OFS_CARD_POWER_CONTROL: reg_rdata <= {24'h0, card_power_control_r[sel]};
        `OFS_SOCKET_CONTROL: reg_rdata <= socket_control_r[sel];
        `OFS_LEGACY_GLOBAL_CONTROL: reg_rdata <= {24'h0, legacy_global_control_r[sel]};
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule // card_bridge_irq_smi_clkrun

`default_nettype wire

// ===== card_bridge_irq_smi_clkrun_tb.sv
/* Self-checking bench for the card bridge interrupt block.
   Assumes the host model on the pins and the shared register map. */
`include "card_irq_map.vh"
`default_nettype none
module card_bridge_irq_smi_clkrun_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic reg_sock = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [3:0] reg_be = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic [1:0] status_event = 2'h0;
  logic [1:0] status_mask = 2'h0;
  logic [1:0] card_idle = 2'h0;
  logic [5:0] src = 6'h00;
  logic [31:0] rd_val;
  wire [31:0] reg_rdata;
  wire [1:0] ccr_out, ccr_oe, ccr_pin, card_clock_stopped;
  wire [6:0] mt_out, mt_oe, mt_pin;
  wire ser_out, ser_oe, ser_pin, power_change_start;
  wire [7:0] start_len, frames;
  wire [19:0] slots;
  int bad_count = 0;
  int checks_done = 0;
  int i;
  always #2.5 mclk = ~mclk;
  card_bridge_irq_smi_clkrun u_card_bridge_irq_smi_clkrun (
    .mclk(mclk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_sock(reg_sock),
    .reg_addr(reg_addr), .reg_be(reg_be), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .card_functional_irq({1'b0, src[3]}), .status_event(status_event),
    .status_mask(status_mask), .card_wake_request({1'b0, src[4]}),
    .card_bus_request({1'b0, src[5]}), .card_clock_run_in(ccr_pin),
    .card_clock_run_out(ccr_out), .card_clock_run_oe(ccr_oe),
    .card_clock_stopped(card_clock_stopped), .card_idle(card_idle),
    .resource_busy(src[0]), .cb_master_busy(src[1]), .pci_master_busy(src[2]),
    .power_change_start(power_change_start), .multifunction_terminals(mt_out),
    .multifunction_terminals_oe(mt_oe), .multifunction_terminals_in(mt_pin),
    .serial_interrupt_line_in(ser_pin), .serial_interrupt_line_out(ser_out),
    .serial_interrupt_line_oe(ser_oe));
  host_side_model u_host_side_model (
    .mclk(mclk), .mt_out(mt_out), .mt_oe(mt_oe), .mt_pin(mt_pin), .ser_out(ser_out),
    .ser_oe(ser_oe), .ser_pin(ser_pin), .ccr_out(ccr_out), .ccr_oe(ccr_oe),
    .ccr_pin(ccr_pin), .start_len(start_len), .slots(slots), .frames(frames));
  // ****
  // Shared tasks
  // ****
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic settle(input int lim);
    if (i >= lim) begin
      chk("wait bound", 32'h0, 32'h1);
      close_out();
    end
  endtask
  task automatic do_reset;
    @(posedge mclk);
    #1 sys_rst = 1'b1;
    src = 6'h00;
    card_idle = 2'h0;
    status_mask = 2'h0;
    repeat (8) @(posedge mclk);
    #1 sys_rst = 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d,
    input logic s);
    @(posedge mclk);
    #1 reg_wr = 1'b1;
    reg_addr = a;
    reg_be = be;
    reg_wdata = d;
    reg_sock = s;
    @(posedge mclk);
    #1 reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic s);
    @(posedge mclk);
    #1 reg_rd = 1'b1;
    reg_addr = a;
    reg_sock = s;
    @(posedge mclk);
    #1 reg_rd = 1'b0;
    rd_val = reg_rdata;
  endtask
  task automatic pend(input logic s, input logic exp);
    rd(`OFS_SYSTEM_CONTROL, s);
    chk("pending", {31'h0, exp}, {31'h0, rd_val[`SC_MAINT_PENDING]});
  endtask
  task automatic wait_pin(input int b, input logic lvl);
    for (i = 0; i < 16 && mt_pin[b] !== lvl; i++) begin
      @(posedge mclk);
      #1;
    end
    settle(16);
    chk("terminal", {31'h0, lvl}, {31'h0, mt_pin[b]});
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_regs;
    do_reset();
    rd(`OFS_SYSTEM_CONTROL, 1'b0);
    chk("system_control", `RST_SYSTEM_CONTROL, rd_val);
    wr(`OFS_TERMINAL_ROUTING, 4'hF, 32'h0FBA_5432, 1'b0);
    rd(`OFS_TERMINAL_ROUTING, 1'b0);
    chk("terminal_routing", 32'h0FBA_5432, rd_val);
    wr(8'h40, 4'hF, 32'hFFFF_FFFF, 1'b0);
    rd(8'h40, 1'b0);
    chk("unmapped", 32'h0, rd_val);
  endtask
  task automatic t_maint;
    do_reset();
    wr(`OFS_SYSTEM_CONTROL, 4'h8, 32'h0100_0000, 1'b0);
    wr(`OFS_SOCKET_CONTROL, 4'hF, 32'h0000_0033, 1'b0);
    pend(1'b0, 1'b1);
    pend(1'b1, 1'b0);
    wr(`OFS_SYSTEM_CONTROL, 4'h8, 32'h0300_0000, 1'b0);
    pend(1'b0, 1'b0);
    wr(`OFS_SYSTEM_CONTROL, 4'h8, 32'h0000_0000, 1'b1);
    wr(`OFS_CARD_POWER_CONTROL, 4'h1, 32'h0000_0030, 1'b1);
    pend(1'b1, 1'b0);
  endtask
  task automatic t_inta;
    do_reset();
    wr(`OFS_TERMINAL_ROUTING, 4'h1, {28'h0, `ROUTE_INTA}, 1'b0);
    #1 status_event = 2'h1;
    @(posedge mclk);
    #1 status_event = 2'h0;
    repeat (8) @(posedge mclk);
    chk("masked change", 32'h1, {31'h0, mt_pin[0]});
    status_mask = 2'h1;
    #1 status_event = 2'h1;
    @(posedge mclk);
    #1 status_event = 2'h0;
    wait_pin(0, 1'b0);
    do_reset();
    wr(`OFS_TERMINAL_ROUTING, 4'h1, {28'h0, `ROUTE_INTA}, 1'b0);
    wr(`OFS_SYSTEM_CONTROL, 4'h8, 32'h0100_0000, 1'b0);
    wr(`OFS_SOCKET_CONTROL, 4'hF, 32'h0000_0033, 1'b0);
    wait_pin(0, 1'b0);
    wr(`OFS_SYSTEM_CONTROL, 4'h8, 32'h0300_0000, 1'b0);
    wait_pin(0, 1'b1);
  endtask
  task automatic t_serial;
    logic [7:0] f;
    do_reset();
    wr(`OFS_DEVICE_CONTROL, 4'h1, {29'h0, `MODE_IRQ_SERIAL, 1'b0}, 1'b0);
    wr(`OFS_SYSTEM_CONTROL, 4'h8, 32'h0500_0000, 1'b0);
    f = frames;
    wr(`OFS_SOCKET_CONTROL, 4'hF, 32'h0000_0033, 1'b0);
    for (i = 0; i < 400 && frames === f; i++) @(posedge mclk);
    settle(400);
    chk("start width", {28'h0, `SER_START_CLKS}, {24'h0, start_len});
    chk("slots", 32'h0000_0004, {12'h0, slots});
  endtask
  task automatic t_clkrun;
    for (int k = 0; k < 7; k++) begin
      do_reset();
      wr(`OFS_TERMINAL_ROUTING, 4'h8, {4'h0, `ROUTE_CLOCK_RUN, 24'h0}, 1'b0);
      card_idle = 2'h3;
      for (i = 0; i < 300 && card_clock_stopped !== 2'h3; i++) @(posedge mclk);
      settle(300);
      chk("card clocks", 32'h3, {30'h0, card_clock_stopped});
      repeat (8) @(posedge mclk);
      chk("stop granted", 32'h1, {31'h0, mt_pin[6]});
      if (k == 6) begin
        wr(`OFS_SYSTEM_CONTROL, 4'h1, 32'h0000_0002, 1'b0);
      end else begin
        src = 6'h01 << k;
      end
      wait_pin(6, 1'b0);
    end
  endtask
  initial begin
    t_regs();
    t_maint();
    t_inta();
    t_serial();
    t_clkrun();
    close_out();
  end
endmodule // card_bridge_irq_smi_clkrun_tb
`default_nettype wire

// ===== card_irq_map.vh
/*
 * Register offsets, field positions, reset values and timing counts
 * for the card bridge interrupt / maintenance-interrupt / clock-run block.
 * Assumes inclusion by bare name from design and bench files.
 */
`ifndef CARD_IRQ_MAP_VH
`define CARD_IRQ_MAP_VH

// Register offsets (byte addresses within the bridge register window)
`define OFS_CARD_POWER_CONTROL 8'h02
`define OFS_SOCKET_CONTROL 8'h10
`define OFS_LEGACY_GLOBAL_CONTROL 8'h1E
`define OFS_SYSTEM_CONTROL 8'h80
`define OFS_TERMINAL_ROUTING 8'h8C
`define OFS_DEVICE_CONTROL 8'h92

// System control fields
`define SC_HOLD_HOST_CLOCK 1
`define SC_MAINT_ENABLE 24
`define SC_MAINT_PENDING 25
`define SC_MAINT_ROUTE 26

// Legacy global control: status-change level/edge mode bit
`define LGC_LEVEL_EDGE 1

// Device control: interrupt signalling mode field [2:1]
`define DC_MODE_LSB 1
`define DC_MODE_MSB 2
`define MODE_PARALLEL 2'h0
`define MODE_IRQ_SERIAL 2'h1
`define MODE_ALL_SERIAL 2'h2

// Terminal routing nibble codes
`define ROUTE_NONE 4'h0
`define ROUTE_INTA 4'h2
`define ROUTE_CLOCK_RUN 4'h2

// Reset values
`define RST_SYSTEM_CONTROL 32'h0000_0000
`define RST_TERMINAL_ROUTING 32'h0000_0000
`define RST_DEVICE_CONTROL 8'h00
`define RST_BYTE 8'h00

// Serial interrupt frame timing: start and stop widths in PCI clocks, slot count, IRQ2 slot index
`define SER_START_CLKS 4'h4
`define SER_STOP_CLKS 4'h2
`define SER_SLOTS 5'h14
`define SER_SLOT_IRQ2 5'h02

`endif

// ===== host_side_model.sv
/* Host side: pulled-up pins, released clock run, serial frame decoder.
   Assumes tri-state style drive from the bridge on every line. */
`default_nettype none
module host_side_model (
  input wire logic mclk, // PCI clock
  input wire logic [6:0] mt_out, // Terminal drive
  input wire logic [6:0] mt_oe, // Terminal enable
  output wire logic [6:0] mt_pin, // Terminal level
  input wire logic ser_out, // Serial drive
  input wire logic ser_oe, // Serial enable
  output wire logic ser_pin, // Serial level
  input wire logic [1:0] ccr_out, // Card clock-run drive
  input wire logic [1:0] ccr_oe, // Card clock-run enable
  output wire logic [1:0] ccr_pin, // Card clock-run level
  output logic [7:0] start_len, // Last start width
  output logic [19:0] slots, // Slots seen low
  output logic [7:0] frames // Frames decoded
);
  timeunit 1ns;
  timeprecision 100ps;
  logic act_r = 1'b0;
  logic ph_r = 1'b0;
  logic [7:0] cnt_r = 8'h00;
  // ****
  // Pins and frame decoder
  // ****
  // Pull-ups on released lines
  assign mt_pin = (mt_oe & mt_out) | ~mt_oe;
  assign ser_pin = ser_oe ? ser_out : 1'b1;
  assign ccr_pin = (ccr_oe & ccr_out) | ~ccr_oe;
  initial frames = 8'h00;
  // Start width, then 3-clock slots, then stop
  always @(posedge mclk) begin
    if (!act_r && !ser_pin) begin
      act_r <= 1'b1;
      ph_r <= 1'b0;
      cnt_r <= 8'h01;
      slots <= 20'h0;
    end else if (act_r && !ph_r) begin
      cnt_r <= ser_pin ? 8'h01 : cnt_r + 8'h01;
      if (ser_pin) begin
        start_len <= cnt_r;
        ph_r <= 1'b1;
      end
    end else if (act_r) begin
      cnt_r <= cnt_r + 8'h01;
      if (cnt_r % 8'h03 == 8'h01 && cnt_r < 8'h3C && !ser_pin) begin
        slots[cnt_r / 8'h03] <= 1'b1;
      end
      if (cnt_r > 8'h3D && ser_pin) begin
        act_r <= 1'b0;
        frames <= frames + 8'h01;
      end
    end
  end
endmodule // host_side_model
`default_nettype wire

// ===== serial_irq_frame.v
/*
 * Serial interrupt frame engine: start, twenty three-clock slots, stop.
 * Assumes the slot vector is stable enough to be sampled at each slot.
 */
`include "card_irq_map.vh"
`default_nettype none

module serial_irq_frame (
  input wire mclk, // PCI clock
  input wire sys_rst, // Synchronous reset, active high
  input wire enable, // Serial mode selected
  input wire [19:0] slot_state, // IRQ0..15 then INTA..INTD, high = asserted
  input wire line_in, // Serial line level seen from pin
  output reg line_out, // Serial line drive value
  output reg line_oe, // Serial line drive enable
  output reg busy // Frame in progress
);

  // ****************************************
  // States
  // ****************************************
  localparam ST_IDLE = 2'h0;
  localparam ST_START = 2'h1;
  localparam ST_SLOTS = 2'h2;
  localparam ST_STOP = 2'h3;

  reg [1:0] state_r;
  reg [3:0] cnt_r;
  reg [4:0] slot_r;
  reg [1:0] phase_r;
  reg last_r;

  always @(posedge mclk) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
      cnt_r <= 4'h0;
      slot_r <= 5'h00;
      phase_r <= 2'h0;
      line_out <= 1'b1;
      line_oe <= 1'b0;
      busy <= 1'b0;
      last_r <= 1'b0;
    end else begin
      last_r <= |slot_state;
      case (state_r)
        ST_IDLE: begin
          line_oe <= 1'b0;
          busy <= 1'b0;
          if (enable && (|slot_state) && !last_r && line_in) begin
            state_r <= ST_START;
            cnt_r <= `SER_START_CLKS;
            line_out <= 1'b0;
            line_oe <= 1'b1;
            busy <= 1'b1;
          end
        end
        ST_START: begin
          if (cnt_r == 4'h1) begin
            state_r <= ST_SLOTS;
            line_out <= 1'b1;
            line_oe <= 1'b0;
            slot_r <= 5'h00;
            phase_r <= 2'h0;
          end
          cnt_r <= cnt_r - 4'h1;
        end
        ST_SLOTS: begin
          if (phase_r == 2'h0) begin
            line_out <= ~slot_state[slot_r];
            line_oe <= slot_state[slot_r];
          end else if (phase_r == 2'h1) begin
            line_out <= 1'b1;
          end else begin
            line_oe <= 1'b0;
          end
          if (phase_r == 2'h2) begin
            phase_r <= 2'h0;
            if (slot_r == `SER_SLOTS - 5'h01) begin
              state_r <= ST_STOP;
              cnt_r <= `SER_STOP_CLKS;
            end
            slot_r <= slot_r + 5'h01;
          end else begin
            phase_r <= phase_r + 2'h1;
          end
        end
        ST_STOP: begin
          line_out <= 1'b0;
          line_oe <= (cnt_r != 4'h0);
          if (cnt_r == 4'h0) begin
            state_r <= ST_IDLE;
            line_out <= 1'b1;
          end else begin
            cnt_r <= cnt_r - 4'h1;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

endmodule // serial_irq_frame

`default_nettype wire
